// [boot_sel_pkg.sv]
// Purpose: Shared constants and types for the boot mode selector
// Assumes: Word-addressed register port, 200 MHz system clock
// Notes:   Offsets are word addresses as the register port sees them
package boot_sel_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [15:0] EMULATION_BOOT_KEY_OFS      = 16'h0D00;
    localparam logic [15:0] EMU_SEL_OFS      = 16'h0D01;
    localparam logic [15:0] SCALE_OFS        = 16'h0D02;
    localparam logic [15:0] CALLBACK_OFS     = 16'h0D04;
    localparam logic [15:0] CLK_CFG_OFS      = 16'h0D10;
    localparam logic [15:0] STATUS_OFS       = 16'h0D11;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          SYSCLK_DIVIDER_SELECT_LSB       = 0;
    localparam int          PLLMUL_LSB       = 8;
    localparam logic [1:0]  SYSCLK_DIVIDER_SELECT_RESET     = 2'h0;
    localparam logic [1:0]  SYSCLK_DIVIDER_SELECT_BY_ONE    = 2'h3;
    localparam logic [3:0]  PLLMUL_RESET     = 4'h0;
    localparam logic [15:0] VALID_KEY        = 16'h55AA;
    localparam logic [15:0] KEY_RESET        = 16'h0000;
    localparam logic [15:0] SEL_RESET        = 16'h0000;
    localparam logic [31:0] WORD_RESET       = 32'h0000_0000;
    localparam int          SETTLE_CYCLES    = 2;

    // ------------------------------------------------------------
    // Boot scratch area, entry points
    // ------------------------------------------------------------
    localparam logic [21:0] SCRATCH_LO       = 22'h00_0002;
    localparam logic [21:0] SCRATCH_HI       = 22'h00_004E;
    localparam logic [21:0] RAM_ENTRY        = 22'h00_0000;
    localparam logic [21:0] FLASH_ENTRY      = 22'h3F_7FF6;
    localparam logic [21:0] OTP_ENTRY        = 22'h3D_7800;

    // ------------------------------------------------------------
    // Mode codes held in the selector words
    // ------------------------------------------------------------
    localparam logic [15:0] CODE_PARALLEL    = 16'h0000;
    localparam logic [15:0] CODE_UART        = 16'h0001;
    localparam logic [15:0] CODE_WAIT        = 16'h0002;
    localparam logic [15:0] CODE_GET         = 16'h0003;
    localparam logic [15:0] CODE_SPI         = 16'h0004;
    localparam logic [15:0] CODE_I2C         = 16'h0005;
    localparam logic [15:0] CODE_OTP         = 16'h0006;
    localparam logic [15:0] CODE_CAN         = 16'h0007;
    localparam logic [15:0] CODE_RAM         = 16'h000A;
    localparam logic [15:0] CODE_FLASH       = 16'h000B;

    typedef enum logic [3:0] {
        M_PARALLEL, M_UART, M_WAIT, M_GET, M_SPI,
        M_I2C, M_OTP, M_CAN, M_RAM, M_FLASH
    } boot_mode_t;

endpackage

// [strap_sync.sv]
// Purpose: Two-stage synchroniser for asynchronous strap and pod pins
// Assumes: Inputs are quasi-static levels
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module strap_sync #(
    parameter int WIDTH = 3
) (
    input  wire logic             clk,   // System clock
    input  wire logic             rst,   // Async reset, active high
    input  wire logic [WIDTH-1:0] d,     // Asynchronous pins
    output logic      [WIDTH-1:0] q      // Synchronised levels
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// [boot_mode_selector.sv]
// Purpose: Reset-time boot configuration and boot mode selection
// Assumes: Loaders and watchdog are outside; pins arrive asynchronously
// Notes:   Debugger reset restarts the flow but spares the PLL multiplier; the restart sets divider select to three
//
// Operation
// - Set native object mode before any branch
// - Low RAM block map always reads one
// - Keep PLL multiplier, divider select to three
// - Divider select resets to zero, exits three
// - Debugger reset spares multiplier; its restart sets divider select to three
// - Direct branches leave watchdog untouched
// - Loaders: watchdog off, then on and cleared
// - Bad loader key: watchdog on, boot flash
// - Illegal opcode before expansion: watchdog, loop
// - Strap pin pull-ups enabled from reset
// - Loaders enable pin pull-ups, leave enabled
// - Interrupt expansion block never enabled
// - Scratch RAM 0x0002-0x004E, no overlap check
// - Test reset selects emulation, else straps
// - Programmed option boots flash unless valid
// - Wait mode loops until debugger reset; emulator connect is only flagged
// - Emulation key gates selector, else wait
// - Emulation selector code decode, others wait
// - Stand-alone start writes key and code
// - Vector-area words act as plain RAM
// - Programmed selector decode, others flash
`timescale 1ns/100ps
module boot_mode_selector (
    input  wire logic        clk,                     // System clock, 200 MHz
    input  wire logic        rst,                     // Pin or power-on reset
    input  wire logic        dbg_reset,               // Debugger reset pulse
    input  wire logic        test_reset_pin,          // Pod test reset pin
    input  wire logic        boot_strap_high,         // First strap pin
    input  wire logic        boot_strap_low,          // Second strap pin
    input  wire logic [15:0] otp_key,                 // Stored key word
    input  wire logic [15:0] otp_boot_selector,       // Stored mode word
    input  wire logic        illegal_opcode_trap,     // Illegal fetch pulse
    input  wire logic        pie_enabled,             // Expansion block on
    input  wire logic        loader_done,             // Loader finished
    input  wire logic        loader_key_bad,          // Loader saw bad key
    input  wire logic [21:0] loader_entry,            // Loader entry address
    input  wire logic [15:0] reg_addr,                // Register word address
    input  wire logic [31:0] reg_wdata,               // Register write data
    input  wire logic        reg_we,                  // Write strobe
    input  wire logic        reg_re,                  // Read strobe
    output logic      [31:0] reg_rdata,               // Read data, next cycle
    output logic             object_compat_select,    // Native object mode
    output logic             addressing_style_select, // Addressing mode
    output logic             stack_page_zero_select,  // Page-zero mode
    output logic             low_ram_block_map,       // Low RAM mapping
    output logic      [1:0]  sysclk_divider_select,   // Clock divider field
    output logic      [3:0]  pll_multiplier_register, // PLL multiplier
    output logic             interrupt_expansion_en,  // Expansion block enable
    output logic             wd_enable,               // Watchdog enable
    output logic             wd_clear,                // Watchdog counter clear
    output logic             strap_pullup_en,         // Strap pin pull-ups
    output logic             loader_pullup_en,        // Loader pin pull-ups
    output logic             loader_start,            // Start loader pulse
    output logic      [3:0]  loader_mode,             // Loader chosen
    output logic             branch_valid,            // Branch pulse
    output logic      [21:0] branch_addr,             // Branch target
    output logic             boot_done                // Boot flow finished
);

    // ------------------------------------------------------------
    // Decoders
    // ------------------------------------------------------------
    function automatic boot_sel_pkg::boot_mode_t emu_decode(input logic [15:0] code);
        unique case (code)
            boot_sel_pkg::CODE_PARALLEL: emu_decode = boot_sel_pkg::M_PARALLEL;
            boot_sel_pkg::CODE_UART:     emu_decode = boot_sel_pkg::M_UART;
            boot_sel_pkg::CODE_GET:      emu_decode = boot_sel_pkg::M_GET;
            boot_sel_pkg::CODE_SPI:      emu_decode = boot_sel_pkg::M_SPI;
            boot_sel_pkg::CODE_I2C:      emu_decode = boot_sel_pkg::M_I2C;
            boot_sel_pkg::CODE_OTP:      emu_decode = boot_sel_pkg::M_OTP;
            boot_sel_pkg::CODE_RAM:      emu_decode = boot_sel_pkg::M_RAM;
            boot_sel_pkg::CODE_FLASH:    emu_decode = boot_sel_pkg::M_FLASH;
            default:                     emu_decode = boot_sel_pkg::M_WAIT;
        endcase
    endfunction

    function automatic boot_sel_pkg::boot_mode_t otp_decode(input logic [15:0] code);
        unique case (code)
            boot_sel_pkg::CODE_UART: otp_decode = boot_sel_pkg::M_UART;
            boot_sel_pkg::CODE_SPI:  otp_decode = boot_sel_pkg::M_SPI;
            boot_sel_pkg::CODE_I2C:  otp_decode = boot_sel_pkg::M_I2C;
            boot_sel_pkg::CODE_OTP:  otp_decode = boot_sel_pkg::M_OTP;
            boot_sel_pkg::CODE_CAN:  otp_decode = boot_sel_pkg::M_CAN;
            default:                 otp_decode = boot_sel_pkg::M_FLASH;
        endcase
    endfunction

    function automatic logic is_loader(input boot_sel_pkg::boot_mode_t m);
        is_loader = (m == boot_sel_pkg::M_PARALLEL) || (m == boot_sel_pkg::M_UART) ||
                    (m == boot_sel_pkg::M_SPI) || (m == boot_sel_pkg::M_I2C) ||
                    (m == boot_sel_pkg::M_CAN);
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [2:0] pins_s;
    logic       trst_s;
    logic       strap_hi_s;
    logic       strap_lo_s;

    strap_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({test_reset_pin, boot_strap_high, boot_strap_low}),
        .q   (pins_s)
    );

    assign trst_s     = pins_s[2];
    assign strap_hi_s = pins_s[1];
    assign strap_lo_s = pins_s[0];

    // ------------------------------------------------------------
    // Boot sequencer
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_SETTLE, S_CONFIG, S_SELECT, S_PROGRAMMED_MODE_OPTION, S_WD_OFF, S_LOAD,
        S_WD_ON, S_BRANCH, S_WAIT, S_TRAP, S_DONE
    } state_t;

    state_t                   state_q;
    boot_sel_pkg::boot_mode_t mode_q;
    logic [1:0]               settle_q;
    logic                     emu_boot_q;
    logic                     key_bad_q;
    logic                     emu_seen_q;
    logic [15:0]              emulation_boot_key_q;
    logic [15:0]              emu_sel_q;
    logic [31:0]              scale_q;
    logic [31:0]              callback_q;
    logic                     seed_emu;
    logic [15:0]              seed_code;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= S_SETTLE;
        end else if (dbg_reset) begin
            state_q <= S_SETTLE;
        end else if (illegal_opcode_trap && !pie_enabled) begin
            state_q <= S_TRAP;
        end else begin
            unique case (state_q)
                S_SETTLE:  if (settle_q == 2'(boot_sel_pkg::SETTLE_CYCLES)) begin
                    state_q <= S_CONFIG;
                end
                S_CONFIG:  state_q <= S_SELECT;
                S_SELECT:  begin
                    if (mode_q == boot_sel_pkg::M_GET) begin
                        state_q <= S_PROGRAMMED_MODE_OPTION;
                    end else if (mode_q == boot_sel_pkg::M_WAIT) begin
                        state_q <= S_WAIT;
                    end else if (is_loader(mode_q)) begin
                        state_q <= S_WD_OFF;
                    end else begin
                        state_q <= S_BRANCH;
                    end
                end
                S_PROGRAMMED_MODE_OPTION: state_q <= is_loader(mode_q) ? S_WD_OFF : S_BRANCH;
                S_WD_OFF:  state_q <= S_LOAD;
                S_LOAD:    begin
                    if (loader_key_bad) begin
                        state_q <= S_BRANCH;
                    end else if (loader_done) begin
                        state_q <= S_WD_ON;
                    end
                end
                S_WD_ON:   state_q <= S_BRANCH;
                S_BRANCH:  state_q <= S_DONE;
                S_WAIT:    state_q <= S_WAIT;
                S_TRAP:    state_q <= S_TRAP;
                S_DONE:    state_q <= S_DONE;
            endcase
        end
    end

    // Settle counter lets the synchroniser fill before the one sample
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settle_q <= '0;
        end else if (dbg_reset) begin
            settle_q <= '0;
        end else if (state_q == S_SETTLE) begin
            settle_q <= settle_q + 2'h1;
        end
    end

    // Mode sampled once, then only narrowed by the programmed option
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_q     <= boot_sel_pkg::M_WAIT;
            emu_boot_q <= 1'b0;
        end else if (state_q == S_CONFIG) begin
            emu_boot_q <= trst_s;
            if (trst_s) begin
                mode_q <= (emulation_boot_key_q == boot_sel_pkg::VALID_KEY) ?
                          emu_decode(emu_sel_q) : boot_sel_pkg::M_WAIT;
            end else begin
                unique case ({strap_hi_s, strap_lo_s})
                    2'b00: mode_q <= boot_sel_pkg::M_PARALLEL;
                    2'b01: mode_q <= boot_sel_pkg::M_UART;
                    2'b10: mode_q <= boot_sel_pkg::M_WAIT;
                    2'b11: mode_q <= boot_sel_pkg::M_GET;
                endcase
            end
        end else if (state_q == S_SELECT && mode_q == boot_sel_pkg::M_GET) begin
            mode_q <= (otp_key == boot_sel_pkg::VALID_KEY) ?
                      otp_decode(otp_boot_selector) : boot_sel_pkg::M_FLASH;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            key_bad_q <= 1'b0;
        end else if (dbg_reset) begin
            key_bad_q <= 1'b0;
        end else if (state_q == S_LOAD && loader_key_bad) begin
            key_bad_q <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            emu_seen_q <= 1'b0;
        end else if (state_q == S_WAIT && trst_s) begin
            emu_seen_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Native mode and clock setup
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            object_compat_select    <= 1'b0;
            addressing_style_select <= 1'b0;
            stack_page_zero_select  <= 1'b0;
        end else if (dbg_reset) begin
            object_compat_select    <= 1'b0;
        end else if (state_q == S_CONFIG) begin
            object_compat_select    <= 1'b1;
            addressing_style_select <= 1'b0;
            stack_page_zero_select  <= 1'b0;
        end
    end

    assign low_ram_block_map      = 1'b1;
    assign interrupt_expansion_en = 1'b0;

    // Pin or power-on reset loads these; debugger reset does not, but the restarted config sets divider select to three
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sysclk_divider_select   <= boot_sel_pkg::SYSCLK_DIVIDER_SELECT_RESET;
            pll_multiplier_register <= boot_sel_pkg::PLLMUL_RESET;
        end else if (state_q == S_CONFIG && !dbg_reset) begin
            sysclk_divider_select   <= boot_sel_pkg::SYSCLK_DIVIDER_SELECT_BY_ONE;
        end else if (reg_we && reg_addr == boot_sel_pkg::CLK_CFG_OFS &&
                     state_q == S_DONE) begin
            sysclk_divider_select   <= reg_wdata[boot_sel_pkg::SYSCLK_DIVIDER_SELECT_LSB +: 2];
            pll_multiplier_register <= reg_wdata[boot_sel_pkg::PLLMUL_LSB +: 4];
        end
    end

    // ------------------------------------------------------------
    // Watchdog, pull-ups, loader and branch
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wd_enable <= 1'b1;
            wd_clear  <= 1'b0;
        end else begin
            wd_clear <= 1'b0;
            if (state_q == S_TRAP) begin
                wd_enable <= 1'b1;
            end else if (state_q == S_WD_OFF) begin
                wd_enable <= 1'b0;
            end else if (state_q == S_WD_ON) begin
                wd_enable <= 1'b1;
                wd_clear  <= 1'b1;
            end else if (state_q == S_LOAD && loader_key_bad) begin
                wd_enable <= 1'b1;
            end
        end
    end

    assign strap_pullup_en = 1'b1;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loader_pullup_en <= 1'b0;
            loader_start     <= 1'b0;
            loader_mode      <= '0;
        end else begin
            loader_start <= 1'b0;
            if (state_q == S_WD_OFF) begin
                loader_pullup_en <= 1'b1;
                loader_start     <= 1'b1;
                loader_mode      <= mode_q;
            end
        end
    end

    // Direct branches never reach the watchdog states
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            branch_valid <= 1'b0;
            branch_addr  <= '0;
            boot_done    <= 1'b0;
        end else if (dbg_reset) begin
            branch_valid <= 1'b0;
            boot_done    <= 1'b0;
        end else begin
            branch_valid <= (state_q == S_BRANCH) && object_compat_select;
            if (state_q == S_BRANCH) begin
                boot_done <= 1'b1;
                if (key_bad_q) begin
                    branch_addr <= boot_sel_pkg::FLASH_ENTRY;
                end else begin
                    unique case (mode_q)
                        boot_sel_pkg::M_RAM:   branch_addr <= boot_sel_pkg::RAM_ENTRY;
                        boot_sel_pkg::M_OTP:   branch_addr <= boot_sel_pkg::OTP_ENTRY;
                        boot_sel_pkg::M_FLASH: branch_addr <= boot_sel_pkg::FLASH_ENTRY;
                        default:               branch_addr <= loader_entry;
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Vector-area RAM words and own registers
    // ------------------------------------------------------------
    assign seed_emu  = (state_q == S_CONFIG) && !trst_s;
    always_comb begin
        unique case ({strap_hi_s, strap_lo_s})
            2'b00: seed_code = boot_sel_pkg::CODE_PARALLEL;
            2'b01: seed_code = boot_sel_pkg::CODE_UART;
            2'b10: seed_code = boot_sel_pkg::CODE_WAIT;
            2'b11: seed_code = boot_sel_pkg::CODE_GET;
        endcase
    end

    // Seeding wins over a software write in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            emulation_boot_key_q <= boot_sel_pkg::KEY_RESET;
            emu_sel_q <= boot_sel_pkg::SEL_RESET;
        end else if (seed_emu) begin
            emulation_boot_key_q <= boot_sel_pkg::VALID_KEY;
            emu_sel_q <= seed_code;
        end else if (reg_we) begin
            if (reg_addr == boot_sel_pkg::EMULATION_BOOT_KEY_OFS) begin
                emulation_boot_key_q <= reg_wdata[15:0];
            end
            if (reg_addr == boot_sel_pkg::EMU_SEL_OFS) begin
                emu_sel_q <= reg_wdata[15:0];
            end
        end
    end

    // Plain storage; nothing here feeds the expansion block
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scale_q    <= boot_sel_pkg::WORD_RESET;
            callback_q <= boot_sel_pkg::WORD_RESET;
        end else if (reg_we) begin
            if (reg_addr == boot_sel_pkg::SCALE_OFS) begin
                scale_q <= reg_wdata;
            end
            if (reg_addr == boot_sel_pkg::CALLBACK_OFS) begin
                callback_q <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_re) begin
            unique case (reg_addr)
                boot_sel_pkg::EMULATION_BOOT_KEY_OFS:  reg_rdata <= {16'h0000, emulation_boot_key_q};
                boot_sel_pkg::EMU_SEL_OFS:  reg_rdata <= {16'h0000, emu_sel_q};
                boot_sel_pkg::SCALE_OFS:    reg_rdata <= scale_q;
                boot_sel_pkg::CALLBACK_OFS: reg_rdata <= callback_q;
                boot_sel_pkg::CLK_CFG_OFS:  reg_rdata <= {20'h0_0000, pll_multiplier_register,
                                                          6'h00, sysclk_divider_select};
                boot_sel_pkg::STATUS_OFS:   reg_rdata <= {16'h0000, 4'(state_q), 4'(mode_q),
                                                          emu_seen_q, key_bad_q, emu_boot_q,
                                                          wd_enable, low_ram_block_map,
                                                          stack_page_zero_select,
                                                          addressing_style_select,
                                                          object_compat_select};
                default:                    reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule

// [boot_sel_checker.sv]
// Purpose: Port assertions for the boot selector
// Assumes: One clock, rst async high
// Notes:   Attached by bind
`timescale 1ns/100ps
module boot_sel_checker (
    input wire logic       clk, rst, dbg_reset, branch_valid, loader_start, wd_clear, // Flow
    input wire logic       low_ram_block_map, interrupt_expansion_en, strap_pullup_en, // Ties
    input wire logic       object_compat_select, addressing_style_select, wd_enable, // Mode
    input wire logic       stack_page_zero_select, // Page zero
    input wire logic [1:0] sysclk_divider_select   // Divider
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_map_high: assert property (low_ram_block_map) else $error("map low");
    a_expansion_off: assert property (!interrupt_expansion_en) else $error("pie on");
    a_pullups_on: assert property (strap_pullup_en) else $error("pullups off");
    a_native_branch: assert property (branch_valid |-> object_compat_select &&
        !addressing_style_select && !stack_page_zero_select) else $error("not native");
    a_div_exit: assert property (branch_valid |-> sysclk_divider_select == 2'h3)
        else $error("div not 3");
    a_dbg_keeps_div: assert property (dbg_reset && sysclk_divider_select == 2'h3 |=>
        $stable(sysclk_divider_select)) else $error("div lost");
    a_loader_wd_off: assert property (loader_start |-> ##[0:1] !wd_enable)
        else $error("wd on");
    a_clear_branch: assert property (wd_clear |-> wd_enable ##[1:3] branch_valid)
        else $error("no branch");
    cover property (branch_valid);
    cover property (loader_start);
    cover property (wd_clear);
endmodule
bind boot_mode_selector boot_sel_checker chk (.*);

// [boot_loader_model.sv]
// Purpose: Loader stand-in on the far side
// Assumes: Answers alternate prompt and slow
// Notes:   Key fault only on request
`timescale 1ns/100ps
module boot_loader_model (
    input  wire logic clk, bad, loader_start, // Clock, fault, start
    output logic      loader_done,            // Done pulse
    output logic      loader_key_bad          // Bad key pulse
);
    int cnt = 0;
    bit slow = 0;
    always @(posedge clk) begin
        cnt <= loader_start ? (slow ? 17 : 3) : (cnt > 0 ? cnt - 1 : 0);
        slow <= slow ^ loader_start;
        loader_done <= cnt == 1 && !bad;
        loader_key_bad <= cnt == 1 && bad;
    end
endmodule

// [boot_mode_selector_test.sv]
// Purpose: Directed boot flow test
// Assumes: Partner answers loader starts
// Notes:   Pod pin and straps set here
`timescale 1ns/100ps
module boot_mode_selector_test;
    logic clk = 0, rst = 1, dbg_reset = 0, illegal_opcode_trap = 0, pie_enabled = 0, bad = 0;
    logic reg_we = 0, reg_re = 0, test_reset_pin = 0, boot_strap_high = 0, boot_strap_low = 0;
    logic [15:0] otp_key = 16'h0000, otp_boot_selector = 16'h0000, reg_addr = 16'h0000;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d;
    logic [21:0] loader_entry = 22'h00_1234, branch_addr;
    logic [3:0]  pll_multiplier_register, loader_mode;
    logic [1:0]  sysclk_divider_select;
    logic object_compat_select, addressing_style_select, stack_page_zero_select, wd_clear;
    logic low_ram_block_map, interrupt_expansion_en, strap_pullup_en, loader_pullup_en;
    logic loader_done, loader_key_bad, loader_start, branch_valid, boot_done, wd_enable;
    int failures = 0, checked = 0, cyc = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (++cyc == 20000) give_verdict;
    boot_mode_selector DUT (.*);
    boot_loader_model partner (.*);
    task automatic cmp(logic [31:0] g, e);
        checked++;
        if (g !== e) failures++;
        if (g !== e) $display("MISMATCH %0t got %h exp %h", $time, g, e);
    endtask
    task automatic bus(logic w, logic [15:0] a, logic [31:0] v);
        @(posedge clk) {reg_we, reg_re, reg_addr, reg_wdata} <= {w, !w, a, v};
        @(posedge clk) {reg_we, reg_re} <= 2'h0;
        #1 d = reg_rdata;
    endtask
    // Selector write, debugger restart, bounded wait for the branch
    task automatic go(logic [15:0] s, o, logic b, w, logic [21:0] a);
        logic seen = 0;
        bus(1, 16'h0D01, {16'h0000, s});
        @(posedge clk) {otp_boot_selector, bad, dbg_reset} <= {o, b, 1'b1};
        @(posedge clk) dbg_reset <= 0;
        for (int i = 0; i < 90 && !seen; i++) @(posedge clk) #1 seen = branch_valid;
        cmp(32'(seen), 32'(!w));
        if (seen) cmp(32'(branch_addr), 32'(a));
        if (seen) cmp(32'(boot_done), 32'h1);
    endtask
    task automatic give_verdict;
        failures += int'(cyc >= 20000);
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        cmp(32'(sysclk_divider_select), 32'h0);
        rst <= 0;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) {boot_strap_high, boot_strap_low} <= 2'(k);
            go(16'h000B, 0, 0, k == 2, k == 3 ? 22'h3F_7FF6 : loader_entry);
            bus(0, 16'h0D01, 0);
            cmp(d, k);
        end
        bus(0, 16'h0D00, 0);
        cmp(d, 32'h0000_55AA);
        bus(1, 16'h0D02, 32'h1234_5678);
        bus(1, 16'h0D04, 32'h9ABC_DEF0);
        bus(1, 16'h0D10, 32'h0000_0501);
        bus(0, 16'h0D02, 0);
        cmp(d, 32'h1234_5678);
        bus(0, 16'h0D04, 0);
        cmp(d, 32'h9ABC_DEF0);
        bus(0, 16'h0D10, 0);
        cmp(d, 32'h0000_0501);
        @(posedge clk) {test_reset_pin, otp_key} <= {1'b1, 16'h55AA};
        go(16'h000A, 0, 0, 0, 22'h00_0000);
        go(16'h0005, 0, 1, 0, 22'h3F_7FF6);
        go(16'h0003, 16'h0007, 0, 0, loader_entry);
        go(16'h0003, 16'h0009, 0, 0, 22'h3F_7FF6);
        go(16'h0008, 0, 0, 1, 0);
        bus(1, 16'h0D00, 32'h0000_55AB);
        go(16'h000B, 0, 0, 1, 0);
        bus(1, 16'h0D00, 32'h0000_55AA);
        // Trap ignored while expansion is on, taken once it is off
        fork
            go(16'h0001, 0, 0, 1, 0);
            begin
                wait (loader_start);
                #1 cmp(32'(wd_enable), 32'h0);
                cmp(32'(loader_mode), 32'(boot_sel_pkg::M_UART));
                @(posedge clk) {illegal_opcode_trap, pie_enabled} <= 2'h3;
                @(posedge clk) {illegal_opcode_trap, pie_enabled} <= 2'h0;
                @(posedge clk) illegal_opcode_trap <= 1'b1;
                #1 cmp(32'(wd_enable), 32'h0);
                @(posedge clk) illegal_opcode_trap <= 1'b0;
                @(posedge clk) #1 cmp(32'(wd_enable), 32'h1);
            end
        join
        cmp(32'(pll_multiplier_register), 32'h5);
        cmp(32'(sysclk_divider_select), 32'h3);
        cmp(32'(loader_pullup_en), 32'h1);
        give_verdict;
    end
endmodule
